// [design/cafc_filter_ctrl.sv]
// AHB-Lite slave with filter control, masks, identifiers and match logic.
//
// Overview of operation
// R01: enable bit one uses filter, zero ignores.
// R02: two-bit selector picks acceptance mask zero-three.
// R03: five-bit selector names FIFO zero to fifteen.
// R04: software never writes reserved FIFO codes.
// R05: each byte holds enable, mask, FIFO fields.
// R06: first register filters 0-3, second 4-7.
// R07: filter 7 enable sits in bit 31.
// R08: control registers reset to zero, fully read-write.
// R09: mask one bit compares, zero is don't-care.
// R10: accept on enabled match, deliver to selected FIFO.
`timescale 1ns/1ps
`default_nettype none
module cafc_filter_ctrl #(
    parameter int NUM_FILTERS = cafc_pkg::NUM_FILTERS
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Received message from the protocol engine.
    input wire logic msg_valid,
    input wire logic [cafc_pkg::ID_W-1:0] msg_id,
    // Acceptance result.
    output logic accept_valid,
    output logic [3:0] accept_fifo,
    output logic [2:0] accept_filter
);
    localparam int NF = cafc_pkg::NUM_FILTERS;
    localparam int BW = cafc_pkg::BYTE_W;

    // The register map packs exactly eight filters into two words.
    if (NUM_FILTERS != NF) begin : g_bad_filters
        $error("Only eight filters are supported.");
    end

    // Register state.
    logic [31:0] ctrl_r [2];
    logic [31:0] ctrl_nxt [2];
    logic [cafc_pkg::ID_W-1:0] mask_r [cafc_pkg::NUM_MASKS];
    logic [cafc_pkg::ID_W-1:0] mask_nxt [cafc_pkg::NUM_MASKS];
    logic [cafc_pkg::ID_W-1:0] fid_r [NF];
    logic [cafc_pkg::ID_W-1:0] fid_nxt [NF];
    // Address phase capture.
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    // Acceptance outputs.
    logic acc_v_r;
    logic acc_v_nxt;
    logic [3:0] acc_f_r;
    logic [3:0] acc_f_nxt;
    logic [2:0] acc_n_r;
    logic [2:0] acc_n_nxt;

    logic [63:0] ctrl_all;
    logic [NF-1:0] hit;
    logic [NF*4-1:0] hit_fifo;
    logic acc_valid_req;
    logic [7:0] aoff;

    assign ctrl_all = {ctrl_r[1], ctrl_r[0]}; // see R06
    assign aoff = haddr[7:0];
    assign acc_valid_req = hsel && hready && htrans[1];

    // Per-filter compare and field decode.
    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_filt
            logic [BW-1:0] fbyte;
            logic on;
            logic [1:0] msel;
            logic [4:0] fsel;
            logic [cafc_pkg::ID_W-1:0] m;
            assign fbyte = ctrl_all[g*BW +: BW]; // see R05
            assign on = fbyte[cafc_pkg::FLD_ON_POS]; // see R07
            assign msel = fbyte[cafc_pkg::FLD_MASK_LSB +: 2];
            assign fsel = fbyte[cafc_pkg::FLD_FIFO_LSB +: 5];
            assign m = mask_r[msel]; // see R02
            // Masked compare; reserved FIFO codes never deliver.
            assign hit[g] = on && !fsel[cafc_pkg::FIFO_RSVD_BIT]
                && (((msg_id ^ fid_r[g]) & m) == '0); // see R01 R09 R04
            assign hit_fifo[g*4 +: 4] = fsel[3:0]; // see R03
        end
    endgenerate

    // Lowest numbered matching filter wins.
    always_comb begin
        acc_v_nxt = 1'b0;
        acc_f_nxt = acc_f_r;
        acc_n_nxt = acc_n_r;
        if (msg_valid) begin
            for (int i = NF - 1; i >= 0; i--) begin
                if (hit[i]) begin
                    acc_v_nxt = 1'b1; // see R10
                    acc_f_nxt = hit_fifo[i*4 +: 4];
                    acc_n_nxt = 3'(i);
                end
            end
        end
    end

    // Bus next-state logic.
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        fid_nxt = fid_r;
        wr_pend_nxt = 1'b0;
        addr_nxt = addr_r;
        rdata_nxt = rdata_r;
        if (wr_pend_r) begin
            case (addr_r)
                cafc_pkg::OFS_FILTER_CONTROL_0_TO_3: ctrl_nxt[0] = hwdata;
                cafc_pkg::OFS_FILTER_CONTROL_4_TO_7: ctrl_nxt[1] = hwdata;
                cafc_pkg::OFS_MASK_0: mask_nxt[0] = hwdata[28:0];
                cafc_pkg::OFS_MASK_1: mask_nxt[1] = hwdata[28:0];
                cafc_pkg::OFS_MASK_2: mask_nxt[2] = hwdata[28:0];
                cafc_pkg::OFS_MASK_3: mask_nxt[3] = hwdata[28:0];
                default: begin
                    for (int i = 0; i < NF; i++) begin
                        if (addr_r == cafc_pkg::OFS_FILTER_ID_BASE
                            + 8'(4 * i)) begin
                            fid_nxt[i] = hwdata[28:0];
                        end
                    end
                end
            endcase
        end
        if (acc_valid_req) begin
            addr_nxt = {aoff[7:2], 2'b00};
            wr_pend_nxt = hwrite;
            rdata_nxt = 32'h0000_0000;
            if (!hwrite) begin
                case ({aoff[7:2], 2'b00})
                    cafc_pkg::OFS_FILTER_CONTROL_0_TO_3: rdata_nxt = ctrl_r[0];
                    cafc_pkg::OFS_FILTER_CONTROL_4_TO_7: rdata_nxt = ctrl_r[1];
                    cafc_pkg::OFS_MASK_0: rdata_nxt = {3'b000, mask_r[0]};
                    cafc_pkg::OFS_MASK_1: rdata_nxt = {3'b000, mask_r[1]};
                    cafc_pkg::OFS_MASK_2: rdata_nxt = {3'b000, mask_r[2]};
                    cafc_pkg::OFS_MASK_3: rdata_nxt = {3'b000, mask_r[3]};
                    cafc_pkg::OFS_MATCH_STATUS: rdata_nxt =
                        {24'h00_0000, acc_v_r, acc_n_r, acc_f_r};
                    default: begin
                        for (int i = 0; i < NF; i++) begin
                            if ({aoff[7:2], 2'b00} ==
                                cafc_pkg::OFS_FILTER_ID_BASE + 8'(4 * i)) begin
                                rdata_nxt = {3'b000, fid_r[i]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r[0] <= cafc_pkg::RST_FILTER_CONTROL; // see R08
            ctrl_r[1] <= cafc_pkg::RST_FILTER_CONTROL; // see R08
            for (int i = 0; i < cafc_pkg::NUM_MASKS; i++) begin
                mask_r[i] <= cafc_pkg::RST_MASK[28:0];
            end
            for (int i = 0; i < NF; i++) begin
                fid_r[i] <= cafc_pkg::RST_FILTER_ID[28:0];
            end
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            acc_v_r <= 1'b0;
            acc_f_r <= 4'h0;
            acc_n_r <= 3'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            fid_r <= fid_nxt;
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
            acc_v_r <= acc_v_nxt;
            acc_f_r <= acc_f_nxt;
            acc_n_r <= acc_n_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = cafc_pkg::HRESP_OKAY;
    assign accept_valid = acc_v_r;
    assign accept_fifo = acc_f_r;
    assign accept_filter = acc_n_r;
endmodule : cafc_filter_ctrl
`default_nettype wire

// [design/cafc_pkg.sv]
// Package of constants for the CAN acceptance filter control.
package cafc_pkg;
    localparam int NUM_FILTERS = 8;
    localparam int NUM_MASKS = 4;
    localparam int NUM_FIFOS = 16;
    localparam int ID_W = 29;
    localparam int FIFO_SEL_W = 5;
    localparam int MASK_SEL_W = 2;
    localparam int FILT_PER_REG = 4;
    // Field positions inside one filter byte.
    localparam int FLD_ON_POS = 7;
    localparam int FLD_MASK_LSB = 5;
    localparam int FLD_FIFO_LSB = 0;
    localparam int BYTE_W = 8;
    // Register byte addresses.
    localparam logic [7:0] OFS_FILTER_CONTROL_0_TO_3 = 8'h00;
    localparam logic [7:0] OFS_FILTER_CONTROL_4_TO_7 = 8'h04;
    localparam logic [7:0] OFS_MASK_0 = 8'h08;
    localparam logic [7:0] OFS_MASK_1 = 8'h0c;
    localparam logic [7:0] OFS_MASK_2 = 8'h10;
    localparam logic [7:0] OFS_MASK_3 = 8'h14;
    localparam logic [7:0] OFS_FILTER_ID_BASE = 8'h20;
    localparam logic [7:0] OFS_MATCH_STATUS = 8'h40;
    // Reset values.
    localparam logic [31:0] RST_FILTER_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_FILTER_ID = 32'h0000_0000;
    // Reserved FIFO codes have this bit set.
    localparam int FIFO_RSVD_BIT = 4;
    // AHB encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : cafc_pkg

// [dv/cafc_filter_ctrl_properties.sv]
// Checker of bus answers and acceptance outputs of the filter control block.
`timescale 1ns/1ps
`default_nettype none
module cafc_filter_ctrl_properties #(
    parameter int NUM_FILTERS = 8
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Messages and results.
    input wire logic msg_valid,
    input wire logic accept_valid,
    input wire logic [3:0] accept_fifo,
    input wire logic [2:0] accept_filter
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && hresp == 1'b0)
        else $error("bus answer not ready or not okay");
    a_accept_cause: assert property (accept_valid |-> $past(msg_valid))
        else $error("accept without a message");
    a_fifo_hold: assert property (!accept_valid |-> $stable(accept_fifo))
        else $error("fifo number moved without accept");
    a_filter_hold: assert property (!accept_valid |-> $stable(accept_filter))
        else $error("filter number moved without accept");
    a_filter_range: assert property (accept_valid |-> accept_filter < NUM_FILTERS)
        else $error("winning filter out of range");
    a_rdata_hold: assert property
        (!$past(hsel && hready && htrans[1]) |-> $stable(hrdata))
        else $error("read data moved without a transfer");
    a_reset_clear: assert property (disable iff (1'b0)
        !hresetn |-> !accept_valid && hrdata == 32'h0000_0000)
        else $error("outputs not cleared in reset");
    a_accept_pulse: assert property (accept_valid && !$past(msg_valid, 1) |-> 1'b0)
        else $error("accept pulse not tied to a message");
endmodule : cafc_filter_ctrl_properties
bind cafc_filter_ctrl cafc_filter_ctrl_properties #(
    .NUM_FILTERS(NUM_FILTERS)
) u_props (.*);
`default_nettype wire

// [dv/cafc_filter_ctrl_tb_top.sv]
// Self-checking bench for the acceptance filter control block.
`timescale 1ns/1ps
`default_nettype none
module cafc_filter_ctrl_tb_top;
    logic hclk = 0, hresetn = 1, hsel = 0, hwrite = 0, go = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = cafc_pkg::HSIZE_WORD;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q, hrdata;
    logic [28:0] id = 29'h0000_0000, msg_id;
    logic hreadyout, hresp, msg_valid, accept_valid;
    logic [3:0] accept_fifo;
    logic [2:0] accept_filter;
    int mismatches = 0, total_checks = 0, cyc = 0;
    logic [31:0] msk [4] = '{32'h1FFF_FFFF, 32'h0000_0000, 32'h1FFC_0000,
        32'h0000_00FF};
    // Rows: control 0-3, control 4-7, identifier, {valid, filter, fifo}.
    logic [103:0] rows [9] = '{
        {32'h0000_008F, 32'h0000_0000, 32'h0000_0001, 8'h8F},
        {32'h0000_008F, 32'h0000_0000, 32'h0000_0002, 8'h00},
        {32'h0000_000F, 32'h0000_0000, 32'h0000_0001, 8'h00},
        {32'h0000_0090, 32'h0000_0000, 32'h0000_0001, 8'h00},
        {32'h0000_A300, 32'h0000_0000, 32'h0000_1234, 8'h93},
        {32'hC500_0000, 32'h0000_0000, 32'h0000_3333, 8'hB5},
        {32'h0000_0000, 32'hE900_0000, 32'h1FFF_FF08, 8'hF9},
        {32'h0000_0000, 32'h00A2_0000, 32'h0000_0777, 8'hE2},
        {32'h0000_0000, 32'h0000_8E00, 32'h0000_0006, 8'hDE}};
    always #50 hclk = ~hclk;
    cafc_msg_source src (.*);
    cafc_filter_ctrl #(.NUM_FILTERS(8)) uut (.*, .hready(hreadyout));
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] a, input logic
        [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, cafc_pkg::HTRANS_NONSEQ, a, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic send(input logic [28:0] m, input logic [7:0] e);
        @(posedge hclk);
        {go, id} <= {1'b1, m};
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
        chk(accept_valid, e[7]);
        if (e[7]) chk({accept_filter, accept_fifo}, e[6:0]);
    endtask : send
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, 32'h0000_0000, 32'h0000_0000, q);
        chk(q, cafc_pkg::RST_FILTER_CONTROL);
        for (int n = 0; n < 4; n++) xfer(1, 32'h0000_0008 + 32'(4 * n), msk[n], q);
        for (int n = 0; n < 8; n++) xfer(1, 32'h0000_0020 + 32'(4 * n), 32'(n + 1), q);
        foreach (rows[i]) begin
            xfer(1, 32'h0000_0000, rows[i][103:72], q);
            xfer(1, 32'h0000_0004, rows[i][71:40], q);
            xfer(0, 32'h0000_0004, 32'h0000_0000, q);
            chk(q, rows[i][71:40]);
            send(rows[i][36:8], rows[i][7:0]);
        end
        // Two messages on consecutive cycles: a hit, then a miss.
        @(posedge hclk);
        {go, id} <= {1'b1, 29'h0000_0006};
        @(posedge hclk);
        id <= 29'h0000_0007;
        @(posedge hclk);
        go <= 1'b0;
        @(negedge hclk);
        chk({accept_valid, accept_filter, accept_fifo}, 8'hDE);
        @(negedge hclk);
        chk({accept_valid, accept_fifo}, 5'h0E);
        xfer(0, 32'h0000_0040, 32'h0000_0000, q);
        chk(q, 32'h0000_005E);
        xfer(0, 32'h0000_0010, 32'h0000_0000, q);
        chk(q, 32'h1FFC_0000);
        xfer(1, 32'h0000_0000, 32'hFFFF_FFFF, q);
        xfer(0, 32'h0000_0000, 32'h0000_0000, q);
        chk(q, 32'hFFFF_FFFF);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk({accept_valid, accept_filter, accept_fifo}, 8'h00);
        xfer(0, 32'h0000_0000, 32'h0000_0000, q);
        chk(q, cafc_pkg::RST_FILTER_CONTROL);
        final_report();
    end
endmodule : cafc_filter_ctrl_tb_top
`default_nettype wire

// [dv/cafc_msg_source.sv]
// Behavioural protocol engine that hands received identifiers to the block.
`timescale 1ns/1ps
`default_nettype none
module cafc_msg_source (
    // Clock and request from the bench.
    input wire logic hclk,
    input wire logic go,
    input wire logic [cafc_pkg::ID_W-1:0] id,
    // Message towards the block.
    output logic msg_valid,
    output logic [cafc_pkg::ID_W-1:0] msg_id
);
    // Outside a message the identifier is inverted so no stale value matches.
    always_ff @(posedge hclk) begin
        msg_valid <= go;
        msg_id <= go ? id : ~id;
    end
endmodule : cafc_msg_source
`default_nettype wire
